//--- logic/mii_tx_nibble.sv
`timescale 1ns/10ps
`default_nettype none
module mii_tx_nibble
  import mii_tx_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic tx_clk_i,
  input wire logic rx_clk_i,
  input wire logic serial_codec_mode_i,
  input wire logic nib_valid_i,
  input wire nib_in_t nib_i,
  output logic nib_taken_o,
  output mii_tx_t tx_o,
  output logic underrun_o,
  output logic tx_clk_lost_o,
  output logic rx_clk_lost_o
);

  logic tx_rise; // rising edge of the transmit clock seen
  logic rx_rise; // rising edge of the receive clock seen
  tx_state_t state_r; // sequencer state
  logic last_r; // nibble on the pins ends the frame
  logic mode_r; // serial codec mode held for the frame
  logic [LOSS_CNT_W-1:0] tx_cnt_r; // cycles since transmit edge
  logic [LOSS_CNT_W-1:0] rx_cnt_r; // cycles since receive edge
  logic [NIB_W-1:0] nib_mask; // lanes in use for this mode

  // transmit clock edge finder
  link_edge_sync u_tx_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(tx_clk_i),
    .rise_o(tx_rise),
    .fall_o()
  );

  // receive clock edge finder, used only to watch it run
  link_edge_sync u_rx_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(rx_clk_i),
    .rise_o(rx_rise),
    .fall_o()
  );

  // serial mode keeps only the lowest data lane
  always_comb
  begin
    nib_mask = serial_codec_mode_i ? SER_MASK : ~NIB_IDLE;
  end

  // transmit clock watchdog; a stalled clock aborts the frame
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tx_cnt_r <= LOSS_ZERO;
      tx_clk_lost_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (tx_rise)
      begin
        tx_cnt_r <= LOSS_ZERO;
        tx_clk_lost_o <= 1'b0;
      end
      else if (tx_cnt_r != LOSS_LIMIT)
        tx_cnt_r <= tx_cnt_r + LOSS_STEP;
      else
        tx_clk_lost_o <= 1'b1;
    end
  end

  // receive clock watchdog, status only
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rx_cnt_r <= LOSS_ZERO;
      rx_clk_lost_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rx_rise)
      begin
        rx_cnt_r <= LOSS_ZERO;
        rx_clk_lost_o <= 1'b0;
      end
      else if (rx_cnt_r != LOSS_LIMIT)
        rx_cnt_r <= rx_cnt_r + LOSS_STEP;
      else
        rx_clk_lost_o <= 1'b1;
    end
  end

  // sequencer and pins: pin changes follow a transmit clock edge, or a lost transmit clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_IDLE;
      tx_o <= TX_IDLE;
      last_r <= 1'b0;
      mode_r <= 1'b0;
      underrun_o <= 1'b0;
      nib_taken_o <= 1'b0;
    end
    // enable low freezes the taken strobe too, so no pulse is lost
    else if (ce_i)
    begin
      nib_taken_o <= 1'b0; // strobe lasts one enabled cycle
      if (tx_clk_lost_o)
      begin
        // dead clock: quietly close any frame
        state_r <= ST_IDLE;
        tx_o <= TX_IDLE;
        last_r <= 1'b0;
      end
      else if (tx_rise)
      begin
        underrun_o <= 1'b0;
        unique case (state_r)
          ST_IDLE:
          begin
            // start with the first offered nibble
            // one idle period must pass after a frame
            if (nib_valid_i && !tx_o.en)
            begin
              state_r <= ST_SEND;
              tx_o.en <= 1'b1;
              tx_o.d <= nib_i.d & nib_mask;
              last_r <= nib_i.last;
              mode_r <= serial_codec_mode_i;
              nib_taken_o <= 1'b1;
            end
            else
              tx_o <= TX_IDLE;
          end
          ST_SEND:
          begin
            if (last_r)
            begin
              state_r <= ST_IDLE;
              tx_o <= TX_IDLE;
              last_r <= 1'b0;
            end
            else if (nib_valid_i)
            begin
              tx_o.en <= 1'b1;
              tx_o.d <= nib_i.d & (mode_r ? SER_MASK : ~NIB_IDLE);
              last_r <= nib_i.last;
              nib_taken_o <= 1'b1;
            end
            else
            begin
              // source ran dry mid frame: end it and report
              state_r <= ST_IDLE;
              tx_o <= TX_IDLE;
              underrun_o <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // enable moves only after a transmit edge or a lost transmit clock
  a_en_on_edge: assert property (@(posedge clk_i) disable iff (srst_i)
    $changed(tx_o.en) |-> $past(tx_rise) || $past(tx_clk_lost_o))
    else $error("enable changed without a transmit clock edge");

  // enable rises only from idle with a taken nibble
  a_en_rise_start: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(tx_o.en) |-> nib_taken_o && state_r == ST_SEND)
    else $error("enable rose without a frame start");

  // a final nibble is followed by enable low on the next edge
  a_last_drop: assert property (@(posedge clk_i) disable iff (srst_i)
    (ce_i && tx_rise && state_r == ST_SEND && last_r) |=>
    !tx_o.en && state_r == ST_IDLE)
    else $error("enable not dropped after final nibble");

  // each taken nibble is driven as given on the lanes its mode uses
  a_nib_driven: assert property (@(posedge clk_i) disable iff (srst_i)
    nib_taken_o |-> tx_o.en &&
    (tx_o.d == ($past(nib_i.d) & (mode_r ? SER_MASK : ~NIB_IDLE))))
    else $error("taken nibble not on the pins");

  // upper lanes stay low in serial codec mode
  a_ser_lanes: assert property (@(posedge clk_i) disable iff (srst_i)
    (tx_o.en && mode_r) |-> (tx_o.d & ~SER_MASK) == NIB_IDLE)
    else $error("upper lanes driven in serial mode");

  // enable high means the sequencer is mid frame
  a_en_in_frame: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_o.en |-> state_r == ST_SEND)
    else $error("enable high outside a frame");

  a_reset_low: assert property (@(posedge clk_i)
    $past(srst_i) |-> !tx_o.en && tx_o.d == NIB_IDLE && !nib_taken_o)
    else $error("pins not low after reset");

  // frame with held pins stays fixed between edges
  a_hold_between: assert property (@(posedge clk_i) disable iff (srst_i)
    (!tx_rise && !tx_clk_lost_o) |=> $stable(tx_o))
    else $error("pins moved between transmit edges");

endmodule
`default_nettype wire

//--- logic/mii_tx_pkg.sv
`default_nettype none
package mii_tx_pkg;

  // system clock period and link clock watchdog figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_LOSS_NS = 1000;
  localparam int CLK_LOSS_CYC = CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W = 8;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(CLK_LOSS_CYC);
  localparam logic [LOSS_CNT_W-1:0] LOSS_ZERO = 8'h00;
  localparam logic [LOSS_CNT_W-1:0] LOSS_STEP = 8'h01;

  // nibble width and idle values of the pins
  localparam int NIB_W = 4;
  localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;
  localparam logic [NIB_W-1:0] SER_MASK = 4'h1;

  // transmit pins toward the transceiver
  typedef struct packed {
    logic en;
    logic [NIB_W-1:0] d;
  } mii_tx_t;

  // one nibble offered by the frame source
  typedef struct packed {
    logic last;
    logic [NIB_W-1:0] d;
  } nib_in_t;

  localparam mii_tx_t TX_IDLE = '{en: 1'b0, d: NIB_IDLE};

  // transmit sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } tx_state_t;

endpackage
`default_nettype wire

//--- logic/link_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module link_edge_sync
  import mii_tx_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic rise_o,
  output logic fall_o
);

  logic s1_r; // first stage, read only by s2_r
  logic s2_r; // second stage
  logic s3_r; // third stage
  logic st_r; // accepted level

  // three flop chain for the foreign clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      st_r <= 1'b0;
    else if (ce_i && (s2_r == s3_r))
      st_r <= s3_r;
  end

  // edge strobes, one system cycle each
  always_comb
  begin
    rise_o = ce_i && (s2_r == s3_r) && s3_r && !st_r;
    fall_o = ce_i && (s2_r == s3_r) && !s3_r && st_r;
  end

endmodule
`default_nettype wire

//--- dv/phy_model.sv
`timescale 1ns/10ps
`default_nettype none
// transceiver model: makes both link clocks and samples the pins
module phy_model
  import mii_tx_pkg::*;
(
  input wire logic run_i,
  input wire mii_tx_t tx_i,
  output logic tx_clk_o,
  output logic rx_clk_o
);
  // nibbles seen while enable was high
  logic [NIB_W-1:0] got_q[$];
  // receive valid looped back from the transmit enable
  logic rx_dv = 1'b0;
  // free running clocks
  // period of 125 ns; they stop only for the loss test
  initial
  begin
    tx_clk_o = 1'b0;
    rx_clk_o = 1'b1;
    forever
    begin
      #62.5;
      if (run_i)
      begin
        tx_clk_o = ~tx_clk_o;
        rx_clk_o = ~rx_clk_o;
      end
    end
  end
  always @(posedge tx_clk_o)
    if (tx_i.en === 1'b1)
      got_q.push_back(tx_i.d);
  // receive valid echoes enable, moving on receive edges only
  always @(posedge rx_clk_o)
    rx_dv <= (tx_i.en === 1'b1);
endmodule
`default_nettype wire

//--- dv/mii_tx_nibble_test.sv
`timescale 1ns/10ps
`default_nettype none
module mii_tx_nibble_test;
  import mii_tx_pkg::*;
  logic clk_i;
  logic srst_i;
  logic ce_i;
  logic run; // link clocks running
  logic serial_codec_mode_i;
  logic nib_valid_i;
  nib_in_t nib_i;
  wire logic tx_clk;
  wire logic rx_clk;
  wire logic nib_taken_o;
  wire mii_tx_t tx_o;
  wire logic tx_lost;
  wire logic rx_lost;
  wire logic underrun;
  int n_fail;
  int comparisons;
  int cycles;
  mii_tx_nibble dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .tx_clk_i(tx_clk), .rx_clk_i(rx_clk),
    .serial_codec_mode_i(serial_codec_mode_i), .nib_valid_i(nib_valid_i),
    .nib_i(nib_i), .nib_taken_o(nib_taken_o), .tx_o(tx_o),
    .underrun_o(underrun), .tx_clk_lost_o(tx_lost),
    .rx_clk_lost_o(rx_lost));
  phy_model phy_u (.run_i(run), .tx_i(tx_o), .tx_clk_o(tx_clk),
    .rx_clk_o(rx_clk));
  // system clock of 10 ns
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // offers n nibbles base, base+1, ... through the handshake
  task automatic send(input int n, input logic [3:0] base, input logic ser);
    int k;
    int w;
    k = 0;
    w = 0;
    phy_u.got_q.delete();
    @(posedge clk_i);
    serial_codec_mode_i <= ser;
    nib_valid_i <= 1'b1;
    nib_i <= '{last: (n == 1), d: base};
    while (k < n && w < 3000)
    begin
      @(posedge clk_i);
      w++;
      // next nibble once the last one was consumed
      if (nib_taken_o === 1'b1)
      begin
        k++;
        nib_i <= '{last: (k == n - 1), d: base + k[3:0]};
        nib_valid_i <= (k < n);
      end
    end
    repeat (40) @(posedge clk_i);
  endtask
  // a whole frame must reach the pins, then enable falls
  task automatic t_frame(input logic ser);
    logic [3:0] e;
    int i;
    send(5, 4'hA, ser);
    chk(8'(phy_u.got_q.size()), 8'h05);
    for (i = 0; i < 5; i++)
    begin
      e = 4'hA + i[3:0];
      if (ser)
        e = e & SER_MASK;
      chk({4'h0, phy_u.got_q[i]}, {4'h0, e});
    end
    chk({3'h0, tx_o}, 8'h00);
    chk({7'h00, phy_u.rx_dv}, 8'h00);
  endtask
  // source runs dry mid frame: frame ends, underrun pulses
  task automatic t_underrun();
    int w;
    logic seen;
    w = 0;
    seen = 1'b0;
    phy_u.got_q.delete();
    @(posedge clk_i);
    serial_codec_mode_i <= 1'b0;
    nib_valid_i <= 1'b1;
    nib_i <= '{last: 1'b0, d: 4'h3};
    while (nib_taken_o !== 1'b1 && w < 100)
    begin
      @(posedge clk_i);
      w++;
    end
    nib_valid_i <= 1'b0;
    for (w = 0; w < 40; w++)
    begin
      @(posedge clk_i);
      if (underrun === 1'b1)
        seen = 1'b1;
    end
    chk({7'h00, seen}, 8'h01);
    chk({7'h00, underrun}, 8'h00);
    chk(8'(phy_u.got_q.size()), 8'h01);
    chk({3'h0, tx_o}, 8'h00);
  endtask
  // clock enable low holds the pins mid frame
  task automatic t_freeze();
    int w;
    w = 0;
    @(posedge clk_i);
    nib_valid_i <= 1'b1;
    nib_i <= '{last: 1'b1, d: 4'h7};
    while (nib_taken_o !== 1'b1 && w < 100)
    begin
      @(posedge clk_i);
      w++;
    end
    nib_valid_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk({3'h0, tx_o}, 8'h17);
    ce_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk({3'h0, tx_o}, 8'h00);
  endtask
  // reset in mid frame forces the pins low at once
  task automatic t_reset_mid();
    int w;
    w = 0;
    @(posedge clk_i);
    nib_valid_i <= 1'b1;
    nib_i <= '{last: 1'b0, d: 4'h9};
    while (nib_taken_o !== 1'b1 && w < 100)
    begin
      @(posedge clk_i);
      w++;
    end
    srst_i <= 1'b1;
    nib_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk({2'h0, nib_taken_o, tx_o}, 8'h00);
    repeat (40) @(posedge clk_i);
    chk({3'h0, tx_o}, 8'h00);
  endtask
  // stopped link clocks raise the loss flags, running ones clear them
  task automatic t_loss();
    run <= 1'b0;
    repeat (150) @(posedge clk_i);
    chk({5'h00, tx_lost, rx_lost, tx_o.en}, 8'h06);
    run <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk({6'h00, tx_lost, rx_lost}, 8'h00);
  endtask
  // bounded run time
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      test_done();
    end
  end
  // main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    srst_i = 1'b1;
    ce_i = 1'b1;
    run = 1'b1;
    serial_codec_mode_i = 1'b0;
    nib_valid_i = 1'b0;
    nib_i = '0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk({2'h0, nib_taken_o, tx_o}, 8'h00);
    chk({7'h00, underrun}, 8'h00);
    t_frame(1'b0);
    t_frame(1'b1);
    t_underrun();
    t_freeze();
    t_loss();
    t_reset_mid();
    t_frame(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
